// ---- hdl/adc_ctrl_pkg.sv ----
// Package: register layouts, reset values and encodings for the converter control block
package adc_ctrl_pkg;

   // Register indices on the register port
   localparam logic [2:0] REG_REF_RANGE  = 3'h0;
   localparam logic [2:0] REG_TRIGGER    = 3'h1;
   localparam logic [2:0] REG_CHAN_SEL   = 3'h2;
   localparam logic [2:0] REG_RESULT_LO  = 3'h3;
   localparam logic [2:0] REG_RESULT_HI  = 3'h4;
   localparam logic [2:0] REG_RESULT_UB  = 3'h5;

   // Reset values
   localparam logic [7:0]  REF_RANGE_RST = 8'h00;
   localparam logic [7:0]  TRIGGER_RST   = 8'h00;
   localparam logic [7:0]  CHAN_SEL_RST  = 8'h00;
   localparam logic [15:0] RESULT_RST    = 16'h0000;
   localparam logic [7:0]  RESULT_UB_RST = 8'h00;

   // Writable bit masks, reserved bits read as zero
   localparam logic [7:0] REF_RANGE_MASK = 8'hEA;
   localparam logic [7:0] TRIGGER_MASK   = 8'hC3;
   localparam logic [7:0] CHAN_SEL_MASK  = 8'hFF;

   // Field positions
   localparam int POS_REF_HI      = 7;
   localparam int POS_REF_LO      = 6;
   localparam int POS_NEG_REF     = 5;
   localparam int POS_RANGE_MODE  = 3;
   localparam int POS_TAG_EN      = 1;
   localparam int POS_TRIG_HI     = 7;
   localparam int POS_TRIG_LO     = 6;
   localparam int POS_SRC_HI      = 1;
   localparam int POS_SRC_LO      = 0;
   localparam int POS_INT_SRC     = 7;
   localparam int POS_AMP1        = 6;
   localparam int POS_AMP0        = 5;

   // Scan walks four slots; the last start code is 12
   localparam logic [1:0] SCAN_LAST_SLOT  = 2'h3;
   localparam logic [3:0] SCAN_LAST_START = 4'hC;
   localparam logic [4:0] CODE_ALL_SWITCH = 5'h1F;

   typedef enum logic [1:0] {
      REF_SUPPLY = 2'b00,
      REF_EXT    = 2'b01,
      REF_INT    = 2'b10,
      REF_BAD    = 2'b11
   } pos_ref_t;

   typedef enum logic [1:0] {
      TRIG_NONE    = 2'b00,
      TRIG_SW      = 2'b01,
      TRIG_HW_NOW  = 2'b10,
      TRIG_HW_WAIT = 2'b11
   } trig_mode_t;

   // Analog mux steering sent toward the converter core
   typedef struct packed {
      pos_ref_t   pos_ref;
      logic       neg_ref_ext;
      logic [15:0] ain_onehot;
      logic       all_switch;
      logic       temp_sensor;
      logic       int_reference;
      logic       amp0;
      logic       amp1;
      logic       prohibited;
   } mux_sel_t;

   // Conversion completion from the converter core
   typedef struct packed {
      logic        done;
      logic [11:0] value;
   } conv_t;

endpackage : adc_ctrl_pkg

// ---- hdl/adc_result_gate.sv ----
// Range check and result store for finished conversions
`timescale 1ns/1ps
`default_nettype none
module adc_result_gate
   import adc_ctrl_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire conv_t       i_conv,
   input  wire logic        i_range_mode,
   input  wire logic [7:0]  i_upper_limit,
   input  wire logic [7:0]  i_lower_limit,
   input  wire logic        i_scan_mode,
   input  wire logic        i_tag_en,
   input  wire logic [3:0]  i_chan_idx,
   output logic             o_conv_irq,
   output logic [15:0]      o_result_full,
   output logic [7:0]       o_result_ub
);

   logic        in_range;
   logic        accept;
   logic [15:0] result_q, result_d;
   logic [7:0]  ub_q, ub_d;
   logic        irq_q, irq_d;

   // Only the top byte is compared, limits are inclusive in window mode
   assign in_range = (i_conv.value[11:4] >= i_lower_limit) &&
                     (i_conv.value[11:4] <= i_upper_limit);
   assign accept = i_conv.done && (i_range_mode ? !in_range : in_range);

   // Rejected results leave both result registers untouched
   always_comb begin
      result_d = result_q;
      ub_d     = ub_q;
      irq_d    = accept;
      if (accept) begin
         result_d[11:0]  = i_conv.value;
         result_d[15:12] = (i_scan_mode && i_tag_en) ? i_chan_idx : 4'h0;
         ub_d            = i_conv.value[11:4];
      end
   end

   // Registers only
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         result_q <= RESULT_RST;
         ub_q     <= RESULT_UB_RST;
         irq_q    <= 1'b0;
      end else begin
         result_q <= result_d;
         ub_q     <= ub_d;
         irq_q    <= irq_d;
      end
   end

   assign o_result_full = result_q;
   assign o_result_ub   = ub_q;
   assign o_conv_irq    = irq_q;

   // Irq pulse and stored value follow an accepted conversion by one clock
   property p_store_on_accept;
      @(posedge i_ref_clk) disable iff (i_reset)
      accept |=> (o_conv_irq && o_result_full[11:0] == $past(i_conv.value));
   endproperty
   a_store_on_accept: assert property (p_store_on_accept) else $error("accepted result not stored");

   property p_hold_on_reject;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_conv.done && !accept) |=> ($stable(o_result_full) && $stable(o_result_ub) && !o_conv_irq);
   endproperty
   a_hold_on_reject: assert property (p_hold_on_reject) else $error("rejected result changed registers");

   property p_window_mode;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_conv.done && !i_range_mode && i_conv.value[11:4] >= i_lower_limit
       && i_conv.value[11:4] <= i_upper_limit) |=> o_conv_irq;
   endproperty
   a_window_mode: assert property (p_window_mode) else $error("in-window result lost");

   property p_upper_byte;
      @(posedge i_ref_clk) disable iff (i_reset)
      accept |=> (o_result_ub == o_result_full[11:4]);
   endproperty
   a_upper_byte: assert property (p_upper_byte) else $error("upper byte mismatch");

   property p_tag_zero_select;
      @(posedge i_ref_clk) disable iff (i_reset)
      (accept && !i_scan_mode) |=> (o_result_full[15:12] == 4'h0);
   endproperty
   a_tag_zero_select: assert property (p_tag_zero_select) else $error("tag not zero in select mode");

   property p_tag_scan;
      @(posedge i_ref_clk) disable iff (i_reset)
      (accept && i_scan_mode && i_tag_en) |=> (o_result_full[15:12] == $past(i_chan_idx));
   endproperty
   a_tag_scan: assert property (p_tag_scan) else $error("scan tag wrong");

endmodule : adc_result_gate
`default_nettype wire

// ---- hdl/adc_channel_trigger_result_ctrl.sv ----
// Register, trigger and channel control for the 12-bit converter
// Overview of operation
// - Bits 7:6 pick positive reference: supply, external pin, internal, prohibited.
// - Bit 5 picks ground or external negative reference pin.
// - Range mode clear: irq inside limits; set: irq outside limits.
// - A result failing the range check updates neither result register.
// - Scan mode with tag enable puts input index in result bits 15:12.
// - Select mode reads the four tag bits as zero.
// - Trigger bits 7:6: software, hardware no-wait, hardware with power-up wait.
// - Source bits 1:0: timer ch1, event link, real-time clock, interval timer.
// - Select mode codes 0-15 pick inputs 0-15; 11111 picks all-channel switch.
// - Internal source: code 0 temperature, code 1 reference; amp bits pick amplifiers.
// - Scan start code n converts inputs n to n+3 as slots 0 to 3.
// - Full result resets zero, loads 12-bit result into bits 11:0.
// - Upper byte register holds top eight result bits, resets zero.
// - Range check compares only the top eight result bits to limits.
// - Single scan clears run bit after all four slots converted.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_trigger_result_ctrl
   import adc_ctrl_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_reg_wr,
   input  wire logic [2:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   input  wire logic        i_run_bit,
   input  wire logic        i_converter_enable_bit,
   input  wire logic        i_scan_select_mode_bit,
   input  wire logic        i_single_conv,
   input  wire logic [7:0]  i_upper_limit,
   input  wire logic [7:0]  i_lower_limit,
   input  wire logic        i_timer_ch1_irq,
   input  wire logic        i_event_link_unit,
   input  wire logic        i_rtc_irq,
   input  wire logic        i_interval_timer_irq,
   input  wire conv_t       i_conv,
   output mux_sel_t         o_mux_sel,
   output trig_mode_t       o_trig_mode,
   output logic             o_sw_start_mode,
   output logic             o_hw_trigger,
   output logic             o_hw_wait_mode,
   output logic             o_run_clear,
   output logic             o_conv_irq,
   output logic [15:0]      o_result_full
);

   logic [7:0]  ref_range_q, ref_range_d;
   logic [7:0]  trig_q, trig_d;
   logic [7:0]  chan_q, chan_d;
   logic [1:0]  slot_q, slot_d;
   logic        run_clear_q, run_clear_d;
   logic [3:0]  src_pins;
   logic [3:0]  src_sync1_q, src_sync2_q, src_prev_q;
   logic        src_now, src_last;
   logic [3:0]  chan_idx;
   logic [7:0]  result_ub;
   logic        last_slot;

   // Every source pin is synchronised on its own before anything reads it, so a change
   // of source selection never feeds an unsettled pin into the edge detector
   assign src_pins = {i_interval_timer_irq, i_rtc_irq, i_event_link_unit, i_timer_ch1_irq};

   // Two synchroniser stages per source, plus one delayed copy for edge detection
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         src_sync1_q <= 4'h0;
         src_sync2_q <= 4'h0;
         src_prev_q  <= 4'h0;
      end else begin
         src_sync1_q <= src_pins;
         src_sync2_q <= src_sync1_q;
         src_prev_q  <= src_sync2_q;
      end
   end

   // Pick the chosen source after synchronisation
   always_comb begin
      src_now  = src_sync2_q[trig_q[POS_SRC_HI:POS_SRC_LO]];
      src_last = src_prev_q[trig_q[POS_SRC_HI:POS_SRC_LO]];
   end

   // Hardware trigger only in the two hardware modes; spacing is software's duty
   assign o_hw_trigger    = trig_q[POS_TRIG_HI] && src_now && !src_last;
   assign o_trig_mode     = trig_mode_t'(trig_q[POS_TRIG_HI:POS_TRIG_LO]);
   assign o_sw_start_mode = (o_trig_mode == TRIG_SW);
   assign o_hw_wait_mode  = (o_trig_mode == TRIG_HW_WAIT);

   // Register writes; the configuration stays live and is not locked by hardware,
   // since keeping writes to the stop state is a software duty
   always_comb begin
      ref_range_d = ref_range_q;
      trig_d      = trig_q;
      chan_d      = chan_q;
      if (i_reg_wr) begin
         case (i_reg_addr)
            REG_REF_RANGE: ref_range_d = i_reg_wdata & REF_RANGE_MASK;
            REG_TRIGGER:   trig_d      = i_reg_wdata & TRIGGER_MASK;
            REG_CHAN_SEL:  chan_d      = i_reg_wdata & CHAN_SEL_MASK;
            default: ;
         endcase
      end
   end

   // Scan slot counter steps on each finished conversion while running in scan mode
   assign last_slot = (slot_q == SCAN_LAST_SLOT);
   always_comb begin
      slot_d      = slot_q;
      run_clear_d = 1'b0;
      if (!i_run_bit) begin
         slot_d = 2'h0;
      end else if (i_conv.done && i_scan_select_mode_bit) begin
         slot_d = slot_q + 2'h1;
         run_clear_d = last_slot && i_single_conv;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ref_range_q <= REF_RANGE_RST;
         trig_q      <= TRIGGER_RST;
         chan_q      <= CHAN_SEL_RST;
         slot_q      <= 2'h0;
         run_clear_q <= 1'b0;
      end else begin
         ref_range_q <= ref_range_d;
         trig_q      <= trig_d;
         chan_q      <= chan_d;
         slot_q      <= slot_d;
         run_clear_q <= run_clear_d;
      end
   end

   assign o_run_clear = run_clear_q;

   // Input index of the conversion in flight
   assign chan_idx = i_scan_select_mode_bit ? (chan_q[3:0] + {2'b00, slot_q}) : chan_q[3:0];

   // Analog mux decode; prohibited channel codes select nothing and are flagged; reference code 11 is flagged but leaves the input selected
   always_comb begin
      o_mux_sel             = '0;
      o_mux_sel.pos_ref     = pos_ref_t'(ref_range_q[POS_REF_HI:POS_REF_LO]);
      o_mux_sel.neg_ref_ext = ref_range_q[POS_NEG_REF];
      if (i_scan_select_mode_bit) begin
         if (chan_q[7:4] == 4'h0 && chan_q[3:0] <= SCAN_LAST_START)
            o_mux_sel.ain_onehot[chan_idx] = 1'b1;
         else
            o_mux_sel.prohibited = 1'b1;
      end else begin
         case (chan_q[7:5])
            3'b000: begin
               if (!chan_q[4])
                  o_mux_sel.ain_onehot[chan_q[3:0]] = 1'b1;
               else if (chan_q[4:0] == CODE_ALL_SWITCH)
                  o_mux_sel.all_switch = 1'b1;
               else
                  o_mux_sel.prohibited = 1'b1;
            end
            3'b100: begin
               o_mux_sel.temp_sensor   = (chan_q[4:0] == 5'h00);
               o_mux_sel.int_reference = (chan_q[4:0] == 5'h01);
               o_mux_sel.prohibited    = (chan_q[4:1] != 4'h0);
            end
            3'b010: begin
               o_mux_sel.amp1       = (chan_q[4:0] == 5'h00);
               o_mux_sel.prohibited = (chan_q[4:0] != 5'h00);
            end
            3'b001: begin
               o_mux_sel.amp0       = (chan_q[4:0] == 5'h00);
               o_mux_sel.prohibited = (chan_q[4:0] != 5'h00);
            end
            default: o_mux_sel.prohibited = 1'b1;
         endcase
      end
      if (o_mux_sel.pos_ref == REF_BAD)
         o_mux_sel.prohibited = 1'b1;
   end

   adc_result_gate u_result_gate (
      .i_ref_clk     (i_ref_clk),
      .i_reset       (i_reset),
      .i_conv        (i_conv),
      .i_range_mode  (ref_range_q[POS_RANGE_MODE]),
      .i_upper_limit (i_upper_limit),
      .i_lower_limit (i_lower_limit),
      .i_scan_mode   (i_scan_select_mode_bit),
      .i_tag_en      (ref_range_q[POS_TAG_EN]),
      .i_chan_idx    (chan_idx),
      .o_conv_irq    (o_conv_irq),
      .o_result_full (o_result_full),
      .o_result_ub   (result_ub)
   );

   // Read mux; reserved bits already held at zero
   always_comb begin
      case (i_reg_addr)
         REG_REF_RANGE: o_reg_rdata = ref_range_q;
         REG_TRIGGER:   o_reg_rdata = trig_q;
         REG_CHAN_SEL:  o_reg_rdata = chan_q;
         REG_RESULT_LO: o_reg_rdata = o_result_full[7:0];
         REG_RESULT_HI: o_reg_rdata = o_result_full[15:8];
         REG_RESULT_UB: o_reg_rdata = result_ub;
         default:       o_reg_rdata = 8'h00;
      endcase
   end

   property p_run_clear;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_run_bit && i_scan_select_mode_bit && i_single_conv && i_conv.done && slot_q == 2'h3)
      |=> o_run_clear;
   endproperty
   a_run_clear: assert property (p_run_clear) else $error("run clear missing after slot 3");

   property p_no_early_clear;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_conv.done && slot_q != 2'h3) |=> !o_run_clear;
   endproperty
   a_no_early_clear: assert property (p_no_early_clear) else $error("run cleared early");

   property p_sw_no_hw;
      @(posedge i_ref_clk) disable iff (i_reset)
      (trig_q[7:6] == 2'b01) |-> !o_hw_trigger;
   endproperty
   a_sw_no_hw: assert property (p_sw_no_hw) else $error("hw trigger in software mode");

   property p_select_input;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_scan_select_mode_bit && chan_q[7:4] == 4'h0)
      |-> (o_mux_sel.ain_onehot == (16'h0001 << chan_q[3:0]));
   endproperty
   a_select_input: assert property (p_select_input) else $error("select decode wrong");

   property p_ref_follow;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_reg_wr && i_reg_addr == 3'h0)
      |=> (o_mux_sel.neg_ref_ext == $past(i_reg_wdata[5]));
   endproperty
   a_ref_follow: assert property (p_ref_follow) else $error("negative reference not applied");

endmodule : adc_channel_trigger_result_ctrl
`default_nettype wire

// ---- tb/adc_conv_model.sv ----
// Behavioural converter core standing beside the control block
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model
   import adc_ctrl_pkg::*;
#(
   parameter int CONV_CYC = 4
)
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_start,
   input  wire logic [11:0] i_value,
   output conv_t            o_conv,
   output logic             o_busy
);
   logic [11:0] last_q;
   int          cnt_q;

   // A start while busy is dropped, so triggers closer than one conversion are lost
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         cnt_q <= 0;
         last_q <= 12'h000;
         o_conv <= '0;
      end else begin
         // Each field is written once per edge; value is meaningless outside done
         o_conv.done  <= (cnt_q == 1);
         o_conv.value <= (cnt_q == 1) ? last_q : ~last_q;
         if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
         end else if (i_start) begin
            cnt_q <= CONV_CYC;
            last_q <= i_value;
         end
      end
   end

   assign o_busy = (cnt_q != 0);
endmodule : adc_conv_model
`default_nettype wire

// ---- tb/adc_channel_trigger_result_ctrl_tb.sv ----
// Self-checking bench for the converter register, trigger and result control
`timescale 1ns/1ps
`default_nettype none
module adc_channel_trigger_result_ctrl_tb;
   import adc_ctrl_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset, reg_wr, run_bit, conv_en, scan_mode, single_conv, start;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, upper, lower, d, r, lo, up, v8;
   logic [3:0]  trg;
   logic [11:0] cvalue;
   logic [15:0] exp_full;
   conv_t       conv;
   mux_sel_t    mux_sel;
   trig_mode_t  trig_mode;
   logic        sw_start, hw_trigger, hw_wait, run_clear, conv_irq, md;
   logic [15:0] result_full;
   int          err_total, n_tests, cyc, seed, n, n0;
   logic [7:0]  codes [7] = '{8'h1F, 8'h80, 8'h81, 8'h40, 8'h20, 8'h10, 8'h82};
   logic [5:0]  flags [7] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h04, 6'h01, 6'h01};

   adc_channel_trigger_result_ctrl u_adc_channel_trigger_result_ctrl (
      .i_ref_clk(ref_clk), .i_reset(reset), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_run_bit(run_bit),
      .i_converter_enable_bit(conv_en), .i_scan_select_mode_bit(scan_mode),
      .i_single_conv(single_conv), .i_upper_limit(upper), .i_lower_limit(lower),
      .i_timer_ch1_irq(trg[0]), .i_event_link_unit(trg[1]), .i_rtc_irq(trg[2]),
      .i_interval_timer_irq(trg[3]), .i_conv(conv), .o_mux_sel(mux_sel),
      .o_trig_mode(trig_mode), .o_sw_start_mode(sw_start), .o_hw_trigger(hw_trigger),
      .o_hw_wait_mode(hw_wait), .o_run_clear(run_clear), .o_conv_irq(conv_irq),
      .o_result_full(result_full));

   adc_conv_model u_adc_conv_model (
      .i_ref_clk(ref_clk), .i_reset(reset), .i_start(start), .i_value(cvalue),
      .o_conv(conv), .o_busy());

   // Free-running 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // Expected range-check verdict, using only the top eight result bits
   function automatic logic exp_irq(input logic m, input logic [11:0] v,
                                    input logic [7:0] l, input logic [7:0] u);
      logic inside_w;
      inside_w = (v[11:4] >= l) && (v[11:4] <= u);
      return m ? !inside_w : inside_w;
   endfunction : exp_irq

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      #1;
      v = reg_rdata;
   endtask : rd

   // Pulse one trigger source and count hardware trigger cycles seen
   task automatic pulse(input int s, output int cnt);
      cnt = 0;
      @(posedge ref_clk);
      trg[s] <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         if (i == 2)
            trg[s] <= 1'b0;
         #1;
         cnt += (hw_trigger === 1'b1);
      end
   endtask : pulse

   // One conversion through the core model, then check irq and both result views
   task automatic convert(input logic [11:0] v, input logic [3:0] tag, input logic m,
                          input logic rc);
      logic acc;
      int   k;
      @(posedge ref_clk);
      start <= 1'b1;
      cvalue <= v;
      acc = exp_irq(m, v, lower, upper);
      @(posedge ref_clk);
      start <= 1'b0;
      k = 0;
      do begin
         @(posedge ref_clk);
         #1;
         k++;
      end while (conv.done !== 1'b1 && k < 20);
      @(posedge ref_clk);
      #1;
      if (acc)
         exp_full = {tag, v};
      chk("conv_irq", 16'(conv_irq), 16'(acc));
      chk("run_clear", 16'(run_clear), 16'(rc));
      chk("result_full", result_full, exp_full);
      rd(REG_RESULT_LO, d);
      chk("result_lo", 16'(d), 16'(exp_full[7:0]));
      rd(REG_RESULT_HI, d);
      chk("result_hi", 16'(d), 16'(exp_full[15:8]));
      rd(REG_RESULT_UB, d);
      chk("result_ub", 16'(d), 16'(exp_full[11:4]));
   endtask : convert

   // Hang guard: well above the expected run length
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      seed = 60644;
      {err_total, n_tests, cyc} = '0;
      {reset, reg_wr, reg_addr, reg_wdata, run_bit, conv_en, scan_mode} = 16'h8000;
      {single_conv, start, cvalue, trg} = '0;
      {upper, lower, exp_full} = '0;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), d);
         chk("reset_read", 16'(d), 16'h0000);
      end
      wr(REG_RESULT_LO, 8'hA5);
      rd(REG_RESULT_LO, d);
      chk("ro_write", 16'(d), 16'h0000);
      $display("test reset done");
      // Random register images while run and enable stay clear
      for (int i = 0; i < 12; i++) begin
         r = 8'($random(seed));
         wr(REG_REF_RANGE, r);
         rd(REG_REF_RANGE, d);
         chk("ref_rw", 16'(d), 16'(r & REF_RANGE_MASK));
         chk("pos_ref", 16'(mux_sel.pos_ref), 16'(r[7:6]));
         chk("neg_ref", 16'(mux_sel.neg_ref_ext), 16'(r[5]));
         chk("ref_bad", 16'(mux_sel.prohibited), 16'(r[7:6] == 2'b11));
         wr(REG_TRIGGER, r);
         rd(REG_TRIGGER, d);
         chk("trig_rw", 16'(d), 16'(r & TRIGGER_MASK));
         chk("trig_mode", 16'(trig_mode), 16'(r[7:6]));
         chk("sw_start", 16'(sw_start), 16'(r[7:6] == 2'b01));
         chk("hw_wait", 16'(hw_wait), 16'(r[7:6] == 2'b11));
      end
      $display("test registers done");
      wr(REG_REF_RANGE, 8'h00);
      for (int c = 0; c < 16; c++) begin
         wr(REG_CHAN_SEL, 8'(c));
         #1;
         chk("ain_onehot", mux_sel.ain_onehot, 16'h0001 << c);
      end
      for (int c = 0; c < 7; c++) begin
         // No conversion runs while an internal source is picked
         wr(REG_CHAN_SEL, codes[c]);
         #1;
         chk("mux_flags", 16'({mux_sel.all_switch, mux_sel.temp_sensor, mux_sel.int_reference,
             mux_sel.amp0, mux_sel.amp1, mux_sel.prohibited}), 16'(flags[c]));
      end
      $display("test channels done");
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 4; s++) begin
            wr(REG_TRIGGER, {2'(m), 4'h0, 2'(s)});
            for (int p = 0; p < 4; p++) begin
               pulse(p, n);
               chk("hw_trigger", 16'(n), 16'((m >= 2) && (p == s)));
            end
         end
      end
      $display("test triggers done");
      wr(REG_CHAN_SEL, 8'h05);
      for (int i = 0; i < 40; i++) begin
         lo = 8'(($random(seed) & 32'h7F) + 32'h10);
         up = lo + 8'(($random(seed) & 32'h3F) + 32'h1);
         md = i[2];
         wr(REG_REF_RANGE, {4'h0, md, 3'h2});
         lower <= lo;
         upper <= up;
         case (i % 4)
            0: v8 = lo;
            1: v8 = up;
            2: v8 = lo - 8'h01;
            default: v8 = up + 8'h01;
         endcase
         if (i >= 16)
            v8 = 8'($random(seed));
         convert({v8, 4'($random(seed))}, 4'h0, md, 1'b0);
      end
      $display("test range done");
      lower <= 8'h00;
      upper <= 8'hFF;
      for (int t = 0; t < 3; t++) begin
         n0 = (t == 0) ? 0 : (t == 1) ? 12 : ($random(seed) & 32'h7FFF) % 13;
         // Last pass runs with tagging off, so the tag field must stay zero
         wr(REG_REF_RANGE, (t == 2) ? 8'h00 : 8'h02);
         wr(REG_CHAN_SEL, 8'(n0));
         scan_mode <= 1'b1;
         single_conv <= 1'b1;
         @(posedge ref_clk);
         conv_en <= 1'b1;
         @(posedge ref_clk);
         run_bit <= 1'b1;
         for (int k = 0; k < 4; k++) begin
            chk("scan_onehot", mux_sel.ain_onehot, 16'h0001 << (n0 + k));
            convert(12'($random(seed)), 4'((t == 2) ? 0 : n0 + k), 1'b0, k == 3);
         end
         @(posedge ref_clk);
         run_bit <= 1'b0;
         conv_en <= 1'b0;
      end
      $display("test scan done");
      // Reset after the scan runs have stopped must clear stored results and configuration
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rd(REG_REF_RANGE, d);
      chk("reset_ref", 16'(d), 16'h0000);
      chk("reset_full", result_full, 16'h0000);
      rd(REG_RESULT_UB, d);
      chk("reset_ub", 16'(d), 16'h0000);
      $display("test reset again done");
      summarize();
   end
endmodule : adc_channel_trigger_result_ctrl_tb
`default_nettype wire
